/* rtl/scw_pkg.sv */
// Purpose: Shared constants and types of the slave supervision block
// Assumes: 200 MHz system clock
// Notes:   Timing counts are derived from times in their own units
package scw_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    // No-exchange timeout, 94.2 ms, held in microseconds
    localparam int TIMEOUT_US    = 94200;
    // Prescaler tick of 100 us keeps granularity far inside the +4 ms margin
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_TICKS = (TIMEOUT_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int STROBE_NS     = 1000;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int TICK_W = 15;
    localparam int TMO_W  = 10;
    localparam int STRB_W = 8;

    // ****************************************************************
    // Status nibble layout
    // ****************************************************************
    localparam int         ST_NVM_BUSY   = 0;
    localparam int         ST_PERIPH     = 1;
    localparam int         ST_UNUSED     = 2;
    localparam int         ST_CORRUPT    = 3;
    localparam logic [3:0] ST_RESET      = 4'h0;
    localparam logic [3:0] OUT_INACTIVE  = 4'h0;

    // ****************************************************************
    // Main control states
    // ****************************************************************
    typedef enum logic [4:0] {
        S_INIT   = 5'h01,
        S_RUN    = 5'h02,
        S_STROBE = 5'h04,
        S_FAULT  = 5'h08,
        S_WDRST  = 5'h10
    } scw_state_t;

    function automatic logic scw_wd_on(input logic locked, input logic inhibit,
                                       input logic gating, input logic safety,
                                       input logic pBit0);
        if (!locked || inhibit) begin
            return 1'b0;
        end
        return !gating || safety || pBit0;
    endfunction : scw_wd_on

endpackage : scw_pkg

/* rtl/scw_timer_if.sv */
// Purpose: Link between the control logic and the timeout timer
// Assumes: Single clock domain
// Notes:   Restart is a one-cycle pulse, run and expired are levels
`timescale 1ns/1ps
interface scw_timer_if;
    logic restart;
    logic run;
    logic expired;

    modport ctrl  (output restart, output run, input expired);
    modport timer (input restart, input run, output expired);
endinterface : scw_timer_if

/* rtl/scw_comm_timer.sv */
// Purpose: Prescaled no-exchange timeout counter
// Assumes: Restart and run come from logic on the same clock
// Notes:   Counter saturates once past the limit, expired is registered
`timescale 1ns/1ps
module scw_comm_timer
    import scw_pkg::*;
#(
    parameter int TICK_CYCLES = scw_pkg::TICK_CYC
) (
    input  wire logic    sys_clk,
    input  wire logic    rst_b,
    scw_timer_if.timer   tmr
);
    import scw_pkg::*;

    logic [TICK_W-1:0] preCnt_ff;
    logic [TMO_W-1:0]  tmoCnt_ff;
    logic              expired_ff;
    logic              tick;

    assign tick        = (preCnt_ff == TICK_W'(TICK_CYCLES - 1));
    assign tmr.expired = expired_ff;

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !tmr.run || tmr.restart || tick) begin
            preCnt_ff <= '0;
        end else begin
            preCnt_ff <= preCnt_ff + 1'b1;
        end
    end

    // ****************************************************************
    // Timeout count
    // ****************************************************************
    // tick based count
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !tmr.run || tmr.restart) begin
            tmoCnt_ff  <= '0;
            expired_ff <= 1'b0;
        end else if (tick && !expired_ff) begin
            tmoCnt_ff  <= tmoCnt_ff + 1'b1;
            // Strictly more than the limit counts as expired
            expired_ff <= (tmoCnt_ff == TMO_W'(TIMEOUT_TICKS));
        end
    end

endmodule : scw_comm_timer

/* rtl/scw_slave_supervisor.sv */
// Purpose: Slave node supervision: state recovery, status nibble, watchdog
// Assumes: Request pulses come one cycle wide from the telegram decoder
// Notes:   Fault input pin is synchronised, all other inputs are local
`timescale 1ns/1ps
module scw_slave_supervisor
    import scw_pkg::*;
#(
    parameter int TICK_CYCLES = scw_pkg::TICK_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       periphery_fault_n,
    input  wire logic       masterMode,
    input  wire logic       exgReq,
    input  wire logic       wparReq,
    input  wire logic       delaReq,
    input  wire logic       resetReq,
    input  wire logic       rdstReq,
    input  wire logic [3:0] exgData,
    input  wire logic [3:0] wparData,
    input  wire logic       addrNonzero,
    input  wire logic       nvmWriteActive,
    input  wire logic       firmParityErr,
    input  wire logic       nvmCorrupt,
    input  wire logic       config_locked_flag,
    input  wire logic       inhibitWdFlag,
    input  wire logic       param_bit0_gating_flag,
    input  wire logic       safetyModeEnable,
    output logic      [3:0] dataOut,
    output logic      [3:0] paramOut,
    output logic            data_strobe_n,
    output logic            param_strobe_n,
    output logic            status_led_a,
    output logic            red_status_led,
    output logic      [3:0] slave_status_nibble,
    output logic            statusValid,
    output logic            exchangeDisable
);
    import scw_pkg::*;

    scw_state_t        state_ff;
    scw_state_t        nxt_state;
    logic [STRB_W-1:0] strbCnt_ff;
    logic              kindData_ff;
    logic              kindParam_ff;
    logic [3:0]        dataOut_ff;
    logic [3:0]        paramOut_ff;
    logic              dataStrobeN_ff;
    logic              paramStrobeN_ff;
    logic              ledA_ff;
    logic              redLed_ff;
    logic [3:0]        status_ff;
    logic              statusValid_ff;
    logic              xdis_ff;
    logic              monActive_ff;
    logic              addrVolatile_ff;
    logic              pfMeta_ff;
    logic              pfSync_ff;
    logic              accept;
    logic              exgTake;
    logic              wparTake;
    logic              strbDone;
    logic              noExch;
    logic              wdOn;
    logic              wdFault;
    logic              illegal;
    logic [3:0]        nibble;

    scw_timer_if tmrIf ();

    scw_comm_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tmr     (tmrIf)
    );

    assign dataOut             = dataOut_ff;
    assign paramOut            = paramOut_ff;
    assign data_strobe_n       = dataStrobeN_ff;
    assign param_strobe_n      = paramStrobeN_ff;
    assign status_led_a        = ledA_ff;
    assign red_status_led      = redLed_ff;
    assign slave_status_nibble = status_ff;
    assign statusValid         = statusValid_ff;
    assign exchangeDisable     = xdis_ff;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    // slave mode only
    assign accept   = (state_ff == S_RUN) && !masterMode && !resetReq;
    assign exgTake  = accept && exgReq && !xdis_ff;
    assign wparTake = accept && wparReq;
    assign strbDone = (strbCnt_ff == STRB_W'(STROBE_CYC - 1));
    assign illegal  = !(state_ff inside {S_INIT, S_RUN, S_STROBE, S_FAULT, S_WDRST});

    assign wdOn    = scw_wd_on(config_locked_flag, inhibitWdFlag,
                               param_bit0_gating_flag, safetyModeEnable, paramOut_ff[0]);
    assign noExch  = monActive_ff && tmrIf.expired;
    assign wdFault = wdOn && noExch && addrNonzero && !nvmWriteActive;

    // ****************************************************************
    // Main control state machine
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_INIT:   nxt_state = S_RUN;
            S_RUN: begin
                if (exgTake || wparTake) begin
                    nxt_state = S_STROBE;
                end else if (wdFault && !masterMode) begin
                    nxt_state = S_FAULT;
                end
            end
            S_STROBE: if (strbDone) nxt_state = S_RUN;
            S_FAULT:  if (strbDone) nxt_state = S_WDRST;
            S_WDRST:  nxt_state = S_INIT;
            default:  nxt_state = S_INIT;
        endcase
        if (resetReq) begin
            nxt_state = S_INIT;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff <= S_INIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************************
    // Strobes and outputs
    // ****************************************************************
    // shared strobe counter
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !(state_ff inside {S_STROBE, S_FAULT})) begin
            strbCnt_ff <= '0;
        end else if (!strbDone) begin
            strbCnt_ff <= strbCnt_ff + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_ff == S_INIT || illegal) begin
            dataOut_ff   <= OUT_INACTIVE;
            paramOut_ff  <= OUT_INACTIVE;
            kindData_ff  <= 1'b0;
            kindParam_ff <= 1'b0;
        end else if (state_ff == S_RUN) begin
            kindData_ff  <= exgTake;
            kindParam_ff <= wparTake;
            if (exgTake) begin
                dataOut_ff <= exgData;
            end
            if (wparTake) begin
                paramOut_ff <= wparData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dataStrobeN_ff  <= 1'b1;
            paramStrobeN_ff <= 1'b1;
        end else begin
            dataStrobeN_ff  <= !((state_ff == S_STROBE && kindData_ff) || state_ff == S_FAULT);
            paramStrobeN_ff <= !((state_ff == S_STROBE && kindParam_ff) || state_ff == S_FAULT);
        end
    end

    // ****************************************************************
    // Exchange disable and monitor
    // ****************************************************************
    // set at watchdog reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            xdis_ff <= 1'b0;
        end else if (state_ff == S_WDRST) begin
            xdis_ff <= 1'b1;
        end else if (wparTake) begin
            xdis_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_ff == S_INIT || illegal || !addrNonzero) begin
            monActive_ff <= 1'b0;
        end else if (accept && delaReq) begin
            monActive_ff <= 1'b0;
        end else if (wparTake) begin
            monActive_ff <= 1'b1;
        end
    end

    assign tmrIf.restart = exgTake || wparTake;
    assign tmrIf.run     = monActive_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ledA_ff   <= 1'b0;
            redLed_ff <= 1'b0;
        end else begin
            ledA_ff   <= !xdis_ff && state_ff != S_INIT;
            redLed_ff <= xdis_ff || (noExch && !tmrIf.restart);
        end
    end

    // ****************************************************************
    // Status nibble
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pfMeta_ff <= 1'b1;
            pfSync_ff <= 1'b1;
        end else begin
            pfMeta_ff <= periphery_fault_n;
            pfSync_ff <= pfMeta_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_ff == S_INIT) begin
            addrVolatile_ff <= 1'b0;
        end else if (accept && delaReq && addrNonzero) begin
            addrVolatile_ff <= 1'b1;
        end
    end

    always_comb begin
        nibble              = ST_RESET;
        nibble[ST_NVM_BUSY] = addrVolatile_ff || nvmWriteActive;
        nibble[ST_PERIPH]   = !pfSync_ff || firmParityErr;
        nibble[ST_UNUSED]   = 1'b0;
        nibble[ST_CORRUPT]  = nvmCorrupt;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            status_ff      <= ST_RESET;
            statusValid_ff <= 1'b0;
        end else begin
            statusValid_ff <= accept && rdstReq;
            if (accept && rdstReq) begin
                status_ff <= nibble;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_illegal_reset;
        illegal |=> state_ff == S_INIT ##1 state_ff == S_RUN;
    endproperty
    a_illegal_reset: assert property (p_illegal_reset) else $error("illegal state kept");

    property p_status_reply;
        accept && rdstReq |=> statusValid_ff && status_ff == $past(nibble);
    endproperty
    a_status_reply: assert property (p_status_reply) else $error("status reply wrong");

    property p_bit0_write;
        accept && rdstReq && nvmWriteActive |=> status_ff[ST_NVM_BUSY];
    endproperty
    a_bit0_write: assert property (p_bit0_write) else $error("bit zero not set");

    property p_bit1_fault;
        accept && rdstReq && !pfSync_ff |=> status_ff[ST_PERIPH];
    endproperty
    a_bit1_fault: assert property (p_bit1_fault) else $error("bit one not set");

    property p_bit2_zero;
        !status_ff[ST_UNUSED];
    endproperty
    a_bit2_zero: assert property (p_bit2_zero) else $error("bit two nonzero");

    property p_led_off;
        exgTake |=> !redLed_ff;
    endproperty
    a_led_off: assert property (p_led_off) else $error("red LED stays on");

    property p_wd_off;
        !config_locked_flag && state_ff == S_RUN && !exgTake && !wparTake
            |=> state_ff != S_FAULT;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog fired while off");

    property p_fault_strobes;
        state_ff == S_FAULT ##1 state_ff == S_FAULT
            |-> !dataStrobeN_ff && !paramStrobeN_ff && $stable(dataOut_ff);
    endproperty
    a_fault_strobes: assert property (p_fault_strobes) else $error("fault strobes bad");

    property p_wd_reset;
        state_ff == S_WDRST && !resetReq
            |=> xdis_ff && state_ff == S_INIT ##1 dataOut_ff == OUT_INACTIVE;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset bad");

    property p_xdis_block;
        xdis_ff && exgReq && !wparReq |=> $stable(dataOut_ff) || state_ff == S_INIT;
    endproperty
    a_xdis_block: assert property (p_xdis_block) else $error("exchange while disabled");

    c_fault:     cover property (state_ff == S_FAULT ##1 state_ff == S_FAULT);
    c_xdis_clr:  cover property (xdis_ff ##1 !xdis_ff);
    c_status:    cover property (statusValid_ff && status_ff[ST_PERIPH]);
    c_red_led:   cover property (!redLed_ff ##1 redLed_ff);

endmodule : scw_slave_supervisor

/* bench/scw_master_model.sv */
// Purpose: Bus master model issuing requests to the supervision block
// Assumes: Requests are sampled on the rising clock edge
// Notes:   Idle data lines carry the inverse of their last value
`timescale 1ns/1ps
module scw_master_model (
    input  wire logic       sys_clk,
    input  wire logic       statusValid,
    input  wire logic [3:0] slave_status_nibble,
    output logic            exgReq,
    output logic            wparReq,
    output logic            delaReq,
    output logic            resetReq,
    output logic            rdstReq,
    output logic      [3:0] exgData,
    output logic      [3:0] wparData
);
    int cyc     = 0;
    int lastCyc = -1000;

    initial begin
        {exgReq, wparReq, delaReq, resetReq, rdstReq} = 5'h00;
        exgData  = 4'h0;
        wparData = 4'h0;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
    end

    // ****************************************************************
    // Requests: kind 0 exchange, 1 parameter, 2 delete, 3 reset, 4 status
    // ****************************************************************
    task automatic issue(input int kind, input logic [3:0] val);
        @(posedge sys_clk);
        #1;
        // Requests during a strobe would be dropped silently
        while (cyc - lastCyc < 203) begin
            @(posedge sys_clk);
            #1;
        end
        exgData  = val;
        wparData = val;
        exgReq   = (kind == 0);
        // gating bit and re-enable via parameter write
        wparReq  = (kind == 1);
        delaReq  = (kind == 2);
        resetReq = (kind == 3);
        rdstReq  = (kind == 4);
        @(posedge sys_clk);
        #1;
        if (kind < 2) begin
            lastCyc = cyc;
        end
        {exgReq, wparReq, delaReq, resetReq, rdstReq} = 5'h00;
        exgData  = ~exgData;
        wparData = ~wparData;
    endtask : issue

    task automatic readStatus(output logic [3:0] nib, output logic vld);
        issue(4, 4'h0);
        // Reply pulse stands for one cycle only, take it now
        vld = statusValid;
        nib = slave_status_nibble;
    endtask : readStatus
endmodule : scw_master_model

/* bench/scw_slave_supervisor_tb_top.sv */
// Purpose: Self-checking bench of the slave supervision block
// Assumes: Prescaler tick shortened to four clocks
// Notes:   Each timeout run takes about four thousand cycles
`timescale 1ns/1ps
module scw_slave_supervisor_tb_top;
    import scw_pkg::*;
    localparam int TCK = 4;
    localparam int TLO = TIMEOUT_TICKS * TCK;
    // Upper bound allows the +4 ms margin
    localparam int THI = (TIMEOUT_TICKS + 40) * TCK;
    // Lock, inhibit, gating, safety, param bit, memory write, fault
    localparam logic [6:0] ROWS [7] = '{7'b0000100, 7'b1100100, 7'b1000001,
        7'b1011001, 7'b1010000, 7'b1010101, 7'b1000010};
    logic sys_clk = 1'b0, rst_b = 1'b0, periphery_fault_n = 1'b1;
    logic addrNonzero = 1'b0, nvmWriteActive = 1'b0, firmParityErr = 1'b0;
    logic nvmCorrupt = 1'b0, config_locked_flag = 1'b0, inhibitWdFlag = 1'b0;
    logic param_bit0_gating_flag = 1'b0, safetyModeEnable = 1'b0;
    logic masterMode = 1'b0;
    logic exgReq, wparReq, delaReq, resetReq, rdstReq, statusValid, vld;
    logic data_strobe_n, param_strobe_n, status_led_a, red_status_led;
    logic exchangeDisable;
    logic [3:0] exgData, wparData, dataOut, paramOut, slave_status_nibble, nib;
    int   fail_count = 0;
    int   check_count = 0;
    int   n;

    scw_slave_supervisor #(.TICK_CYCLES(TCK)) u_scw_slave_supervisor (
        .sys_clk, .rst_b, .periphery_fault_n, .masterMode, .exgReq,
        .wparReq, .delaReq, .resetReq, .rdstReq, .exgData, .wparData,
        .addrNonzero, .nvmWriteActive, .firmParityErr, .nvmCorrupt,
        .config_locked_flag, .inhibitWdFlag, .param_bit0_gating_flag,
        .safetyModeEnable, .dataOut, .paramOut, .data_strobe_n, .param_strobe_n,
        .status_led_a, .red_status_led, .slave_status_nibble, .statusValid,
        .exchangeDisable);

    scw_master_model u_scw_master_model (
        .sys_clk, .statusValid, .slave_status_nibble, .exgReq, .wparReq,
        .delaReq, .resetReq, .rdstReq, .exgData, .wparData);

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic chkBit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chkBit

    task automatic chkNib(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chkNib

    task automatic chkCnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chkCnt

    task automatic conclude();
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    // Counts strobe low time, starting up to four cycles early
    task automatic strobeLen(output int len);
        int w;
        w = 0;
        len = 0;
        while (w < 4 && (data_strobe_n & param_strobe_n)) begin
            tick();
            w++;
        end
        while (len < 400 && !(data_strobe_n & param_strobe_n)) begin
            tick();
            len++;
        end
        if (len >= 400) begin
            fail_count++;
            conclude();
        end
    endtask : strobeLen

    // Red LED and disable flag must stay low throughout
    task automatic quiet(input int cycles);
        logic bad;
        bad = 1'b0;
        repeat (cycles) begin
            tick();
            bad = bad | red_status_led | exchangeDisable;
        end
        chkBit(bad, 1'b0);
    endtask : quiet

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        #400000;
        fail_count++;
        conclude();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        repeat (3) tick();
        chkBit(data_strobe_n & param_strobe_n, 1'b1);
        chkNib(dataOut | paramOut, 4'h0);
        chkBit(status_led_a, 1'b1);
        for (int i = 0; i < 16; i++) begin
            logic [3:0] ib;
            ib = 4'(i);
            {nvmCorrupt, firmParityErr, periphery_fault_n, nvmWriteActive} = ib ^ 4'h2;
            repeat (4) tick();
            u_scw_master_model.readStatus(nib, vld);
            chkBit(vld, 1'b1);
            chkNib(nib, {ib[3], 1'b0, ib[1] | ib[2], ib[0]});
        end
        masterMode = 1'b1;
        u_scw_master_model.readStatus(nib, vld);
        chkBit(vld, 1'b0);
        masterMode = 1'b0;
        {nvmCorrupt, firmParityErr, periphery_fault_n, nvmWriteActive} = 4'h2;
        u_scw_master_model.issue(0, 4'ha);
        tick();
        chkNib(dataOut, 4'ha);
        strobeLen(n);
        chkCnt(n, STROBE_CYC);
        addrNonzero = 1'b1;
        for (int r = 0; r < 7; r++) begin
            logic ef;
            logic pv;
            {config_locked_flag, inhibitWdFlag, param_bit0_gating_flag,
             safetyModeEnable, pv, nvmWriteActive, ef} = ROWS[r];
            u_scw_master_model.issue(1, {3'h5, pv});
            tick();
            chkNib(paramOut, {3'h5, pv});
            chkBit(exchangeDisable, 1'b0);
            tick();
            chkBit(red_status_led, 1'b0);
            n = 2;
            while (n < THI && !red_status_led) begin
                tick();
                n++;
            end
            chkBit(n > TLO && n < THI, 1'b1);
            if (n >= THI) begin
                conclude();
            end
            tick();
            chkBit(data_strobe_n, !ef);
            chkBit(param_strobe_n, !ef);
            chkNib(paramOut, {3'h5, pv});
            if (ef) begin
                strobeLen(n);
                chkCnt(n, STROBE_CYC);
                tick();
                chkNib(paramOut | dataOut, 4'h0);
                chkBit(exchangeDisable, 1'b1);
                chkBit(status_led_a | !red_status_led, 1'b0);
                u_scw_master_model.issue(0, 4'h9);
                tick();
                chkNib(dataOut, 4'h0);
            end else begin
                u_scw_master_model.issue(0, 4'h6);
                repeat (2) tick();
                chkBit(red_status_led, 1'b0);
                chkNib(dataOut, 4'h6);
            end
        end
        nvmWriteActive = 1'b0;
        u_scw_master_model.issue(1, 4'h0);
        u_scw_master_model.issue(2, 4'h0);
        u_scw_master_model.readStatus(nib, vld);
        chkNib(nib, 4'h1);
        quiet(THI);
        u_scw_master_model.issue(3, 4'h0);
        repeat (4) tick();
        u_scw_master_model.readStatus(nib, vld);
        chkNib(nib, 4'h0);
        addrNonzero = 1'b0;
        u_scw_master_model.issue(1, 4'h1);
        quiet(THI + 210);
        conclude();
    end
endmodule : scw_slave_supervisor_tb_top
